// ==== rtl/rip_pkg.sv ====
// Purpose : constants for the clock-domain indirect access port
// Assumes : byte-wide special function register bus, 50 MHz system clock
// Notes   : internal map holds capture and alarm byte groups plus four control bytes
package rip_pkg;
   // ****************************************************************
   // key codes and lock status codes
   // ****************************************************************
   localparam logic [7:0] RIP_KEY_FIRST    = 8'hA5;
   localparam logic [7:0] RIP_KEY_SECOND   = 8'hF1;
   localparam logic [7:0] RIP_ST_LOCKED    = 8'h00;
   localparam logic [7:0] RIP_ST_HALFKEY   = 8'h01;
   localparam logic [7:0] RIP_ST_UNLOCKED  = 8'h02;
   localparam logic [7:0] RIP_ST_DISABLED  = 8'h03;

   // ****************************************************************
   // address register fields
   // ****************************************************************
   localparam int RIP_ADR_BUSY_BIT  = 7;
   localparam int RIP_ADR_AUTO_BIT  = 6;
   localparam int RIP_ADR_SHORT_BIT = 4;
   localparam int RIP_ADR_ADDR_W    = 4;
   localparam logic [7:0] RIP_ADR_RESET = 8'h10;   // short strobe on

   // ****************************************************************
   // internal register map
   // ****************************************************************
   localparam logic [3:0] RIP_CAPTURE_BASE = 4'h0;
   localparam logic [3:0] RIP_CLOCK_CTRL   = 4'h4;
   localparam logic [3:0] RIP_OSC_CTRL     = 4'h5;
   localparam logic [3:0] RIP_OSC_CFG      = 4'h6;
   localparam logic [3:0] RIP_PIN_CFG      = 4'h7;
   localparam logic [3:0] RIP_ALARM_BASE   = 4'h8;
   localparam logic [3:0] RIP_ALARM_LAST   = 4'hB;

   // ****************************************************************
   // transfer timing, in system clock cycles
   // ****************************************************************
   localparam logic [2:0] RIP_XFER_LONG  = 3'd7;
   localparam logic [2:0] RIP_XFER_SHORT = 3'd6;
endpackage : rip_pkg

// ==== rtl/rip_regfile.sv ====
// Purpose : internal byte registers reached only through the indirect port
// Assumes : one byte written or read per strobe
// Notes   : contents are not cleared by system reset
`timescale 1ns/1ns
module rip_regfile
   import rip_pkg::*;
#(
   parameter int NREG = 16
)(
   input  wire logic        clock_i,
   input  wire logic        wr_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic [7:0]  wdata_i,
   output logic      [7:0]  rdata_o,
   output logic      [31:0] capture_o,
   output logic      [31:0] alarm_o
);
   logic [7:0] mem [NREG];

   // ****************************************************************
   // storage; no reset, the block keeps time across device reset
   // ****************************************************************
   always_ff @(posedge clock_i)
   begin
      if (wr_i)
      begin
         mem[addr_i] <= wdata_i;
      end
   end

   assign rdata_o   = mem[addr_i];
   // lowest address is least significant byte
   assign capture_o = {mem[RIP_CAPTURE_BASE + 4'd3], mem[RIP_CAPTURE_BASE + 4'd2],
                       mem[RIP_CAPTURE_BASE + 4'd1], mem[RIP_CAPTURE_BASE]};
   assign alarm_o   = {mem[RIP_ALARM_BASE + 4'd3], mem[RIP_ALARM_BASE + 4'd2],
                       mem[RIP_ALARM_BASE + 4'd1], mem[RIP_ALARM_BASE]};
endmodule : rip_regfile

// ==== rtl/rip_port.sv ====
// Purpose : lock/key protected indirect access port to clock registers
// Assumes : sfr strobes one cycle wide, synchronous to clock_i
// Notes   : address and data registers survive reset by design
`timescale 1ns/1ns
module rip_port
   import rip_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        srst_i,
   // sfr strobes
   input  wire logic        key_wr_i,
   input  wire logic        key_rd_i,
   input  wire logic        adr_wr_i,
   input  wire logic        adr_rd_i,
   input  wire logic        dat_wr_i,
   input  wire logic        dat_rd_i,
   input  wire logic [7:0]  sfr_wdata_i,
   output logic      [7:0]  key_rdata_o,
   output logic      [7:0]  adr_rdata_o,
   output logic      [7:0]  dat_rdata_o,
   output logic      [31:0] capture_o,
   output logic      [31:0] alarm_o
);
   // ****************************************************************
   // lock state machine types
   // ****************************************************************
   typedef enum logic [3:0] {
      LK_LOCKED   = 4'b0001,
      LK_HALFKEY  = 4'b0010,
      LK_UNLOCKED = 4'b0100,
      LK_DISABLED = 4'b1000
   } rip_lock_t;

   rip_lock_t   lock_reg, lock_next;
   logic [7:0]  lock_state_code;
   logic        busy_reg, busy_next;
   logic        dir_wr_reg;            // current transfer is a write
   logic [2:0]  cnt_reg, cnt_next;
   logic        auto_read_enable;
   logic        short_reg;
   logic [3:0]  addr_reg;              // indirect_addr_reg address field
   logic [7:0]  indirect_data_reg;
   logic [7:0]  key_rdata_reg, adr_rdata_reg, dat_rdata_reg;
   logic [7:0]  rf_rdata;
   logic [31:0] cap_w, alm_w;
   logic [31:0] cap_reg, alm_reg;
   logic        unlocked, illegal_acc, start_wr, start_rd, start_any;
   logic        done, rf_wr, incr_en;
   logic [2:0]  xfer_len;

   // ****************************************************************
   // helper functions
   // ****************************************************************
   // capture and alarm groups carry auto-increment
   function automatic logic is_multibyte(input logic [3:0] a);
      is_multibyte = (a <= RIP_CAPTURE_BASE + 4'd3) ||
                     ((a >= RIP_ALARM_BASE) && (a <= RIP_ALARM_LAST));
   endfunction : is_multibyte

   function automatic logic [7:0] code_of(input rip_lock_t s);
      case (s)
         LK_LOCKED   : code_of = RIP_ST_LOCKED;
         LK_HALFKEY  : code_of = RIP_ST_HALFKEY;
         LK_UNLOCKED : code_of = RIP_ST_UNLOCKED;
         LK_DISABLED : code_of = RIP_ST_DISABLED;
         default     : code_of = RIP_ST_DISABLED;
      endcase
   endfunction : code_of

   // ****************************************************************
   // access decode
   // ****************************************************************
   assign unlocked     = (lock_reg == LK_UNLOCKED);
   assign start_wr     = unlocked && dat_wr_i && !busy_reg;
   assign start_rd     = unlocked && !busy_reg && !dat_wr_i &&
                         ((adr_wr_i && sfr_wdata_i[RIP_ADR_BUSY_BIT]) ||
                          (dat_rd_i && auto_read_enable));
   assign start_any    = start_wr || start_rd;
   // a data write or busy-set address write attempted without unlock kills the port
   assign illegal_acc  = !unlocked && (dat_wr_i ||
                         (adr_wr_i && sfr_wdata_i[RIP_ADR_BUSY_BIT]));
   assign xfer_len     = short_reg ? RIP_XFER_SHORT : RIP_XFER_LONG;
   assign done         = busy_reg && (cnt_reg == 3'd1);
   assign rf_wr        = done && dir_wr_reg;
   assign incr_en      = done && is_multibyte(addr_reg);
   assign lock_state_code = code_of(lock_reg);

   // ****************************************************************
   // lock state machine
   // ****************************************************************
   always_comb
   begin
      lock_next = lock_reg;
      case (lock_reg)
         LK_LOCKED   :
            if (illegal_acc)
               lock_next = LK_DISABLED;
            else if (key_wr_i)
               lock_next = (sfr_wdata_i == RIP_KEY_FIRST) ? LK_HALFKEY
                                                          : LK_DISABLED;
         LK_HALFKEY  :
            if (illegal_acc)
               lock_next = LK_DISABLED;
            else if (key_wr_i)
               lock_next = (sfr_wdata_i == RIP_KEY_SECOND) ? LK_UNLOCKED
                                                           : LK_DISABLED;
         LK_UNLOCKED :
            if (key_wr_i)
               lock_next = LK_LOCKED;
         LK_DISABLED :
            lock_next = LK_DISABLED;
         default     :
            lock_next = LK_DISABLED;
      endcase
   end

   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         lock_reg <= LK_LOCKED;
      else
         lock_reg <= lock_next;
   end

   // ****************************************************************
   // transfer sequencer: busy and cycle counter
   // ****************************************************************
   // busy covers the whole transfer; it drops itself at the end
   always_comb
   begin
      busy_next = busy_reg;
      cnt_next  = cnt_reg;
      if (start_any)
      begin
         busy_next = 1'b1;
         cnt_next  = xfer_len;
      end
      else if (busy_reg)
      begin
         cnt_next  = cnt_reg - 3'd1;
         busy_next = !done;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         busy_reg   <= 1'b0;
         cnt_reg    <= 3'd0;
         dir_wr_reg <= 1'b0;
      end
      else
      begin
         busy_reg <= busy_next;
         cnt_reg  <= cnt_next;
         if (start_any)
            dir_wr_reg <= start_wr;
      end
   end

   // ****************************************************************
   // control bits of the address register
   // ****************************************************************
   // short strobe and autoread are control state, so they do reset
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         short_reg        <= RIP_ADR_RESET[RIP_ADR_SHORT_BIT];
         auto_read_enable <= RIP_ADR_RESET[RIP_ADR_AUTO_BIT];
      end
      else if (unlocked && adr_wr_i && !busy_reg)
      begin
         short_reg        <= sfr_wdata_i[RIP_ADR_SHORT_BIT];
         auto_read_enable <= sfr_wdata_i[RIP_ADR_AUTO_BIT];
      end
   end

   // ****************************************************************
   // address and data registers: no reset, they survive device reset
   // ****************************************************************
   always_ff @(posedge clock_i)
   begin
      if (unlocked && adr_wr_i && !busy_reg)
         addr_reg <= sfr_wdata_i[RIP_ADR_ADDR_W-1:0];
      else if (incr_en)
         addr_reg <= addr_reg + 4'd1;
      if (start_wr)
         indirect_data_reg <= sfr_wdata_i;
      else if (done && !dir_wr_reg)
         indirect_data_reg <= rf_rdata;
   end

   // ****************************************************************
   // internal register file, hidden from the sfr bus
   // ****************************************************************
   rip_regfile #(
      .NREG (16)
   ) u_regs (
      .clock_i   (clock_i),
      .wr_i      (rf_wr),
      .addr_i    (addr_reg),
      .wdata_i   (indirect_data_reg),
      .rdata_o   (rf_rdata),
      .capture_o (cap_w),
      .alarm_o   (alm_w)
   );

   // ****************************************************************
   // registered read data; a key read changes nothing
   // ****************************************************************
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         key_rdata_reg <= 8'h00;
         adr_rdata_reg <= 8'h00;
         dat_rdata_reg <= 8'h00;
         cap_reg       <= 32'h0000_0000;
         alm_reg       <= 32'h0000_0000;
      end
      else
      begin
         if (key_rd_i)
            key_rdata_reg <= lock_state_code;
         if (adr_rd_i)
            adr_rdata_reg <= {busy_reg, auto_read_enable, 1'b0, short_reg, addr_reg};
         if (dat_rd_i)
            dat_rdata_reg <= unlocked ? indirect_data_reg : 8'h00;
         cap_reg <= cap_w;
         alm_reg <= alm_w;
      end
   end

   assign key_rdata_o = key_rdata_reg;
   assign adr_rdata_o = adr_rdata_reg;
   assign dat_rdata_o = dat_rdata_reg;
   assign capture_o   = cap_reg;
   assign alarm_o     = alm_reg;

   // ****************************************************************
   // assertions
   // ****************************************************************
   // first key taken from the locked state, nothing illegal beside it
   sequence seq_first_key;
      lock_reg == LK_LOCKED && key_wr_i && sfr_wdata_i == RIP_KEY_FIRST && !illegal_acc;
   endsequence

   // second key after any gap; the gap is left out since no time limit applies
   sequence seq_second_key;
      lock_reg == LK_HALFKEY && key_wr_i && sfr_wdata_i == RIP_KEY_SECOND && !illegal_acc;
   endsequence

   // whole transfer: busy for the strobe length, then idle
   sequence seq_long_busy;
      busy_reg[*7] ##1 !busy_reg;
   endsequence

   sequence seq_short_busy;
      busy_reg[*6] ##1 !busy_reg;
   endsequence

   // lock and key
   AST_FIRST_KEY: assert property (@(posedge clock_i) disable iff (srst_i)
      seq_first_key |=> lock_reg == LK_HALFKEY)
      else $error("first key did not reach half key");
   AST_UNLOCK_SEQ: assert property (@(posedge clock_i) disable iff (srst_i)
      seq_second_key |=> lock_reg == LK_UNLOCKED)
      else $error("key pair did not unlock");
   AST_KEY_WAIT: assert property (@(posedge clock_i) disable iff (srst_i)
      lock_reg == LK_HALFKEY && !key_wr_i && !illegal_acc |=> lock_reg == LK_HALFKEY)
      else $error("half key state left without a key write");
   AST_BAD_KEY: assert property (@(posedge clock_i) disable iff (srst_i)
      lock_reg == LK_HALFKEY && key_wr_i && sfr_wdata_i != RIP_KEY_SECOND
      |=> lock_reg == LK_DISABLED)
      else $error("wrong second key did not disable");
   AST_DATA_HIDDEN: assert property (@(posedge clock_i) disable iff (srst_i)
      !unlocked && dat_rd_i |=> dat_rdata_o == 8'h00)
      else $error("data register visible while not unlocked");
   AST_LOCKED_ACCESS: assert property (@(posedge clock_i) disable iff (srst_i)
      lock_reg == LK_LOCKED && dat_wr_i |=> lock_reg == LK_DISABLED && !busy_reg)
      else $error("locked access did not disable");
   AST_RELOCK: assert property (@(posedge clock_i) disable iff (srst_i)
      unlocked && key_wr_i |=> lock_reg == LK_LOCKED)
      else $error("write while unlocked did not relock");
   AST_DISABLED_STICKY: assert property (@(posedge clock_i) disable iff (srst_i)
      lock_reg == LK_DISABLED |=> lock_reg == LK_DISABLED)
      else $error("disabled state left without reset");
   AST_KEY_READ: assert property (@(posedge clock_i) disable iff (srst_i)
      key_rd_i && !key_wr_i && !illegal_acc |=> key_rdata_o == $past(lock_state_code) &&
      lock_reg == $past(lock_reg))
      else $error("key read wrong or disturbed state");

   // transfers and data
   AST_LONG_XFER: assert property (@(posedge clock_i) disable iff (srst_i)
      start_any && !short_reg |=> seq_long_busy)
      else $error("long transfer not 7 cycles");
   AST_SHORT_XFER: assert property (@(posedge clock_i) disable iff (srst_i)
      start_any && short_reg |=> seq_short_busy)
      else $error("short transfer not 6 cycles");
   AST_BUSY_VISIBLE: assert property (@(posedge clock_i) disable iff (srst_i)
      adr_rd_i |=> adr_rdata_o[RIP_ADR_BUSY_BIT] == $past(busy_reg))
      else $error("busy bit read back wrong");
   AST_INCR: assert property (@(posedge clock_i) disable iff (srst_i)
      done && is_multibyte(addr_reg) && !adr_wr_i |=> addr_reg == $past(addr_reg) + 4'd1)
      else $error("auto increment missed");
   AST_AUTOREAD: assert property (@(posedge clock_i) disable iff (srst_i)
      unlocked && dat_rd_i && auto_read_enable && !busy_reg && !dat_wr_i
      |=> busy_reg && !dir_wr_reg)
      else $error("autoread did not start");
   AST_AUTOREAD_OFF: assert property (@(posedge clock_i) disable iff (srst_i)
      unlocked && dat_rd_i && !auto_read_enable && !busy_reg && !dat_wr_i && !adr_wr_i
      |=> !busy_reg)
      else $error("data read started a transfer with autoread off");
   // case equality: the data register is unknown until first written
   AST_DATA_HOLD: assert property (@(posedge clock_i) disable iff (srst_i)
      !busy_reg && !start_any |=> indirect_data_reg === $past(indirect_data_reg))
      else $error("data changed while idle");
endmodule : rip_port

// ==== tb/rip_cpu_model.sv ====
// Purpose : processor-side model that drives the sfr strobes of the access port
// Assumes : each task is entered just after a falling edge of clock_i
// Notes   : idle write data shows the inverse of the last byte, never a held value
`timescale 1ns/1ns
module rip_cpu_model (
   input  wire logic       clock_i,
   input  wire logic [7:0] key_rdata_i,
   input  wire logic [7:0] adr_rdata_i,
   input  wire logic [7:0] dat_rdata_i,
   output logic      [2:0] wr_o,        // 0 key, 1 address, 2 data
   output logic      [2:0] rd_o,
   output logic      [7:0] sfr_wdata_o
);
   // ****************************************************************
   // bus cycles
   // ****************************************************************
   logic [7:0] last_q;

   // quiet bus at time zero
   initial
   begin
      wr_o        = 3'h0;
      rd_o        = 3'h0;
      last_q      = 8'h00;
      sfr_wdata_o = 8'hFF;
   end

   // one write strobe, then one idle cycle so strobes never abut
   task automatic wr(input int k, input logic [7:0] d);
      wr_o[k]     = 1'b1;
      sfr_wdata_o = d;
      last_q      = d;
      @(negedge clock_i);
      wr_o[k]     = 1'b0;
      sfr_wdata_o = ~last_q;
      @(negedge clock_i);
   endtask : wr

   // read strobe; registered answer is settled by the next falling edge
   task automatic rd(input int k, output logic [7:0] q);
      rd_o[k] = 1'b1;
      @(negedge clock_i);
      rd_o[k] = 1'b0;
      q       = (k == 0) ? key_rdata_i : (k == 1) ? adr_rdata_i : dat_rdata_i;
      @(negedge clock_i);
   endtask : rd

   // write, then read the address every cycle and count the busy samples
   task automatic wr_busy(input int k, input logic [7:0] d, output int n);
      n           = 0;
      wr_o[k]     = 1'b1;
      sfr_wdata_o = d;
      last_q      = d;
      @(negedge clock_i);
      wr_o[k]     = 1'b0;
      sfr_wdata_o = ~last_q;
      rd_o[1]     = 1'b1;
      repeat (12)
      begin
         @(negedge clock_i);
         if (adr_rdata_i[7] === 1'b1) n++;
      end
      rd_o[1] = 1'b0;
      @(negedge clock_i);
   endtask : wr_busy

   // busy poll, called through idle() where a transfer may still run; bounded so a hang is reported
   task automatic poll(output bit ok);
      logic [7:0] q;
      ok = 1'b0;
      repeat (30)
      begin
         if (!ok)
         begin
            rd(1, q);
            if (q[7] === 1'b0) ok = 1'b1;
         end
      end
   endtask : poll
endmodule : rip_cpu_model

// ==== tb/rip_port_tb.sv ====
// Purpose : self-checking bench for the lock/key indirect access port
// Assumes : processor model issues all strobes at falling edges
// Notes   : address and data survive reset, so they are checked after a reset
`timescale 1ns/1ns
module rip_port_tb
   import rip_pkg::*;
;
   logic        clock_i;
   logic        srst_i;
   logic [2:0]  wr_s;
   logic [2:0]  rd_s;
   logic [7:0]  wdata;
   logic [7:0]  key_q;
   logic [7:0]  adr_q;
   logic [7:0]  dat_q;
   logic [31:0] capture;
   logic [31:0] alarm;
   int          n_mismatch;
   int          comparisons;

   // ****************************************************************
   // clock, design and processor model
   // ****************************************************************
   always #10 clock_i = ~clock_i;

   rip_port dut (
      .clock_i(clock_i), .srst_i(srst_i),
      .key_wr_i(wr_s[0]), .key_rd_i(rd_s[0]), .adr_wr_i(wr_s[1]), .adr_rd_i(rd_s[1]),
      .dat_wr_i(wr_s[2]), .dat_rd_i(rd_s[2]), .sfr_wdata_i(wdata),
      .key_rdata_o(key_q), .adr_rdata_o(adr_q), .dat_rdata_o(dat_q),
      .capture_o(capture), .alarm_o(alarm)
   );

   rip_cpu_model u_cpu (
      .clock_i(clock_i), .key_rdata_i(key_q), .adr_rdata_i(adr_q), .dat_rdata_i(dat_q),
      .wr_o(wr_s), .rd_o(rd_s), .sfr_wdata_o(wdata)
   );

   // ****************************************************************
   // shared helpers
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop

   // sync reset held for twelve cycles, released off the sampling edge
   task automatic do_reset();
      srst_i = 1'b1;
      repeat (12) @(negedge clock_i);
      srst_i = 1'b0;
   endtask : do_reset

   task automatic idle();
      bit ok;
      u_cpu.poll(ok);
      if (!ok)
      begin
         n_mismatch++;
         $display("mismatch at %0t: busy never cleared", $time);
         report_and_stop();
      end
   endtask : idle

   task automatic key_is(input logic [7:0] exp, input string what);
      logic [7:0] q;
      u_cpu.rd(0, q);
      chk(q, exp, what);
   endtask : key_is

   task automatic unlock();
      u_cpu.wr(0, RIP_KEY_FIRST);
      u_cpu.wr(0, RIP_KEY_SECOND);
   endtask : unlock

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset_state();
      logic [7:0] q;
      key_is(RIP_ST_LOCKED, "status after reset");
      u_cpu.rd(1, q);
      chk(q & 8'hF0, 8'h10, "control bits after reset");
      key_is(RIP_ST_LOCKED, "status after locked reads");
      $display("test reset_state done");
   endtask : t_reset_state

   // status read between the keys and a long gap must not upset the sequence
   task automatic t_unlock();
      u_cpu.wr(0, RIP_KEY_FIRST);
      key_is(RIP_ST_HALFKEY, "half key status");
      repeat (50) @(negedge clock_i);
      key_is(RIP_ST_HALFKEY, "half key after gap");
      u_cpu.wr(0, RIP_KEY_SECOND);
      key_is(RIP_ST_UNLOCKED, "unlocked status");
      $display("test unlock done");
   endtask : t_unlock

   // first capture byte with long strobe, the rest short, address walks up
   task automatic t_capture();
      int         n;
      logic [7:0] q;
      u_cpu.wr(1, 8'h00);
      u_cpu.wr_busy(2, 8'h11, n);
      chk(n, 7, "long write busy cycles");
      u_cpu.wr(1, 8'h11);
      for (int i = 2; i < 5; i++)
      begin
         u_cpu.wr_busy(2, 8'(i * 8'h11), n);
         chk(n, 6, "short write busy cycles");
      end
      chk(capture, 32'h4433_2211, "capture value");
      u_cpu.rd(1, q);
      chk(q, 8'h14, "address after capture group");
      $display("test capture done");
   endtask : t_capture

   // alarm group written, then read back with one busy set and autoread
   task automatic t_alarm_autoread();
      int         n;
      logic [7:0] q;
      u_cpu.wr(1, 8'h18);
      for (int i = 0; i < 4; i++) u_cpu.wr_busy(2, 8'hA0 + 8'(i), n);
      chk(alarm, 32'hA3A2_A1A0, "alarm value");
      u_cpu.wr(1, 8'hD8);
      for (int i = 0; i < 4; i++)
      begin
         idle();
         u_cpu.rd(2, q);
         chk(q, 8'hA0 + 8'(i), "autoread byte");
      end
      idle();
      u_cpu.rd(1, q);
      chk(q, 8'h5C, "address stops past alarm group");
      $display("test alarm_autoread done");
   endtask : t_alarm_autoread

   // single read of a control byte, held data, survival across reset
   task automatic t_hold_reset();
      logic [7:0] q;
      u_cpu.wr(1, 8'h15);
      u_cpu.wr(2, 8'h5A);
      idle();
      u_cpu.wr(1, 8'h16);
      u_cpu.wr(2, 8'h66);
      idle();
      u_cpu.wr(1, 8'h95);
      idle();
      u_cpu.rd(2, q);
      chk(q, 8'h5A, "control byte read");
      repeat (20) @(negedge clock_i);
      u_cpu.rd(2, q);
      chk(q, 8'h5A, "data held between reads");
      u_cpu.rd(1, q);
      chk(q, 8'h15, "no increment outside groups");
      u_cpu.wr(1, 8'h05);
      do_reset();
      unlock();
      u_cpu.rd(1, q);
      chk(q, 8'h15, "address kept over reset");
      u_cpu.rd(2, q);
      chk(q, 8'h5A, "data kept over reset");
      $display("test hold_reset done");
   endtask : t_hold_reset

   // relock, then four kinds of violation, each after the first from a fresh reset
   task automatic t_relock_disable();
      logic [7:0] q;
      u_cpu.wr(0, 8'h3C);
      key_is(RIP_ST_LOCKED, "relock by any key write");
      u_cpu.wr(1, 8'h80);
      key_is(RIP_ST_DISABLED, "read attempt while locked");
      unlock();
      key_is(RIP_ST_DISABLED, "keys ignored when disabled");
      u_cpu.rd(2, q);
      chk(q, 8'h00, "data hidden when disabled");
      do_reset();
      u_cpu.wr(0, RIP_KEY_FIRST);
      u_cpu.wr(0, 8'h12);
      key_is(RIP_ST_DISABLED, "wrong second key");
      do_reset();
      u_cpu.wr(0, RIP_KEY_SECOND);
      key_is(RIP_ST_DISABLED, "keys out of order");
      do_reset();
      u_cpu.wr(2, 8'h77);
      key_is(RIP_ST_DISABLED, "write attempt while locked");
      do_reset();
      unlock();
      key_is(RIP_ST_UNLOCKED, "usable again after reset");
      $display("test relock_disable done");
   endtask : t_relock_disable

   // ****************************************************************
   // main sequence and run limit
   // ****************************************************************
   initial
   begin
      clock_i     = 1'b0;
      srst_i      = 1'b1;
      n_mismatch  = 0;
      comparisons = 0;
      @(negedge clock_i);
      do_reset();
      t_reset_state();
      t_unlock();
      t_capture();
      t_alarm_autoread();
      t_hold_reset();
      t_relock_disable();
      report_and_stop();
   end

   // last guard against a hang the bounded waits did not catch
   initial
   begin
      #1_000_000;
      n_mismatch++;
      $display("mismatch at %0t: run limit reached", $time);
      report_and_stop();
   end
endmodule : rip_port_tb
